// ---- hw/mcr_pkg.sv ----
package mcr_pkg;

    // ------------------------------------------------------------
    // Register map and layout
    // ------------------------------------------------------------
    localparam logic [7:0]  MCR_ADDR_CONFIG   = 8'h00;
    localparam logic [7:0]  MCR_ADDR_CURRENT  = 8'h01;
    localparam logic [7:0]  MCR_ADDR_BUS      = 8'h02;
    localparam int          MCR_SOFT_RST_BIT  = 15;
    localparam logic [2:0]  MCR_FIXED_BITS    = 3'h6;  // Bits 14..12, read only
    localparam logic [2:0]  MCR_AVG_RESET     = 3'h0;
    localparam logic [2:0]  MCR_CT_RESET      = 3'h4;
    localparam logic [2:0]  MCR_MODE_RESET    = 3'h7;
    localparam logic [15:0] MCR_RESULT_RESET  = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned MCR_CLK_MHZ = 250;
    // Conversion times in ns, codes 0..7
    localparam int unsigned MCR_CT_NS [8] = '{140000, 204000, 332000, 588000,
                                              1100000, 2116000, 4156000, 8244000};
    localparam int          MCR_CNT_W   = 22;

    // Configuration word carrier
    typedef struct packed {
        logic       soft_reset;
        logic [2:0] fixed;
        logic [2:0] sample_average_count;
        logic [2:0] bus_conv_time_sel;
        logic [2:0] shunt_conv_time_sel;
        logic [2:0] mode;
    } mcr_config_t;

    localparam mcr_config_t MCR_CONFIG_RESET = '{
        soft_reset:           1'b0,
        fixed:                MCR_FIXED_BITS,
        sample_average_count: MCR_AVG_RESET,
        bus_conv_time_sel:    MCR_CT_RESET,
        shunt_conv_time_sel:  MCR_CT_RESET,
        mode:                 MCR_MODE_RESET
    };

    // Register port request carrier
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } mcr_req_t;

    typedef enum logic [1:0] {
        MCR_IDLE,
        MCR_CONV_SHUNT,
        MCR_CONV_BUS
    } mcr_state_t;

endpackage

// ---- hw/mcr_monitor.sv ----
// How it works
// - Writing one to config bit 15 resets config, results and sequencer to defaults (read data holds); bit self-clears.
// - Averaging code 0..7 selects 1,4,16,64,128,256,512,1024 samples.
// - Bus conversion time code picks 140us up to 8.244ms.
// - Shunt conversion time code uses the same eight-entry time table.
// - Mode: 000/100 power-down, 001-011 triggered, 101-111 continuous.
// - After reset, continuous conversion of both current and bus voltage.
// - After reset averaging is one sample, both conversion times code 100.
// - Current result is a 16-bit two's complement value; reverse is negative.
// - One current result count is 1.25 mA.
// - With averaging, current result holds the averaged value.
// - Bus result is overwritten by the newest completed reading.
// - With averaging, bus result holds the averaged reading.
// - Bus result step is 1.25 mV; code 32767 equals 40.96 V.
// - Config write aborts conversion, then restarts with the new settings.
// - Reading config never disturbs settings or a running conversion.
// - Bus result bit 15 always reads zero.
`timescale 1ns/1ps

module mcr_monitor
    import mcr_pkg::*;
#(
    // Conversion lengths in clock cycles; shorten for simulation
    parameter int unsigned CONV_CYC [8] = '{
        (MCR_CT_NS[0] * MCR_CLK_MHZ) / 1000, (MCR_CT_NS[1] * MCR_CLK_MHZ) / 1000,
        (MCR_CT_NS[2] * MCR_CLK_MHZ) / 1000, (MCR_CT_NS[3] * MCR_CLK_MHZ) / 1000,
        (MCR_CT_NS[4] * MCR_CLK_MHZ) / 1000, (MCR_CT_NS[5] * MCR_CLK_MHZ) / 1000,
        (MCR_CT_NS[6] * MCR_CLK_MHZ) / 1000, (MCR_CT_NS[7] * MCR_CLK_MHZ) / 1000}
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire mcr_req_t    reg_req,
    output logic [15:0]      reg_rdata,
    input  wire logic [15:0] shunt_sample,
    input  wire logic [14:0] bus_voltage_reading,
    output logic [15:0]      current_result,
    output logic [15:0]      bus_voltage_result,
    output logic             conv_busy,
    output logic             conv_ready
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Cycles minus one for a conversion time code
    function automatic logic [MCR_CNT_W-1:0] conv_last(input logic [2:0] code);
        conv_last = MCR_CNT_W'(CONV_CYC[code] - 1);
    endfunction

    // Log2 of the sample count for an averaging code
    function automatic logic [3:0] avg_shift(input logic [2:0] code);
        case (code)
            3'h0:    avg_shift = 4'h0;
            3'h1:    avg_shift = 4'h2;
            3'h2:    avg_shift = 4'h4;
            3'h3:    avg_shift = 4'h6;
            3'h4:    avg_shift = 4'h7;
            3'h5:    avg_shift = 4'h8;
            3'h6:    avg_shift = 4'h9;
            default: avg_shift = 4'ha;
        endcase
    endfunction

    mcr_config_t            cfg;
    mcr_state_t             state;
    logic [MCR_CNT_W-1:0]   conv_cnt;
    logic [10:0]            samp_idx;
    logic signed [25:0]     acc_shunt;
    logic [24:0]            acc_bus;

    logic                   cfg_write;
    logic                   soft_reset;
    logic                   restart;
    logic                   conv_end;
    logic                   set_end;
    logic                   do_shunt;
    logic                   do_bus;
    logic                   powered;
    logic [10:0]            samp_last;
    logic signed [25:0]     next_acc_shunt;
    logic [24:0]            next_acc_bus;
    mcr_state_t             first_state;
    logic                   start_pending;
    logic signed [25:0]     shunt_total;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign cfg_write  = reg_req.wr && (reg_req.addr == MCR_ADDR_CONFIG);
    assign soft_reset = cfg_write && reg_req.wdata[MCR_SOFT_RST_BIT];
    // Mode bit 0 shunt, bit 1 bus, bit 2 continuous
    assign do_shunt   = cfg.mode[0];
    assign do_bus     = cfg.mode[1];
    assign powered    = do_shunt || do_bus;
    assign first_state = do_shunt ? MCR_CONV_SHUNT : MCR_CONV_BUS;
    assign samp_last  = 11'((12'h001 << avg_shift(cfg.sample_average_count)) - 12'h001);
    assign restart    = reset || cfg_write;

    always_comb begin
        conv_end = 1'b0;
        if (state == MCR_CONV_SHUNT) begin
            conv_end = (conv_cnt == conv_last(cfg.shunt_conv_time_sel));
        end else if (state == MCR_CONV_BUS) begin
            conv_end = (conv_cnt == conv_last(cfg.bus_conv_time_sel));
        end
    end

    // Last selected conversion of the last sample in the set
    assign set_end = conv_end && (samp_idx == samp_last)
                     && ((state == MCR_CONV_BUS) || !do_bus);

    // Accumulators including the sample finishing now
    assign next_acc_shunt = acc_shunt + 26'(signed'(shunt_sample));
    assign next_acc_bus   = acc_bus + 25'(bus_voltage_reading);
    // In a two-quantity set the last shunt sample is already accumulated;
    // adding it again at the bus end would skew the average
    assign shunt_total = (state == MCR_CONV_SHUNT) ? next_acc_shunt : acc_shunt;

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    // Soft reset bit is never stored, so it always reads back zero
    always_ff @(posedge mclk) begin
        if (reset || soft_reset) begin
            cfg <= MCR_CONFIG_RESET;
        end else if (cfg_write) begin
            cfg.sample_average_count <= reg_req.wdata[11:9];
            cfg.bus_conv_time_sel    <= reg_req.wdata[8:6];
            cfg.shunt_conv_time_sel  <= reg_req.wdata[5:3];
            cfg.mode                 <= reg_req.wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    // A config write takes effect next cycle; until then the old set is
    // simply dropped, so no result ever mixes old and new settings.
    always_ff @(posedge mclk) begin
        if (reset || soft_reset) begin
            state    <= MCR_CONV_SHUNT;
            conv_cnt <= '0;
            samp_idx <= '0;
        end else if (cfg_write) begin
            state    <= MCR_IDLE;
            conv_cnt <= '0;
            samp_idx <= '0;
        end else begin
            case (state)
                MCR_IDLE: begin
                    conv_cnt <= '0;
                    if (start_pending) begin
                        state <= first_state;
                    end
                end
                MCR_CONV_SHUNT,
                MCR_CONV_BUS: begin
                    if (!conv_end) begin
                        conv_cnt <= conv_cnt + 1'b1;
                    end else begin
                        conv_cnt <= '0;
                        if (state == MCR_CONV_SHUNT && do_bus) begin
                            state <= MCR_CONV_BUS;
                        end else if (set_end) begin
                            samp_idx <= '0;
                            state    <= cfg.mode[2] ? first_state : MCR_IDLE;
                        end else begin
                            samp_idx <= samp_idx + 1'b1;
                            state    <= first_state;
                        end
                    end
                end
                default: state <= MCR_IDLE;
            endcase
        end
    end

    // Start after a write, once the new settings are in place
    always_ff @(posedge mclk) begin
        start_pending <= cfg_write && !soft_reset && !reset && (reg_req.wdata[1:0] != 2'h0);
    end

    // ------------------------------------------------------------
    // Accumulators
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (restart || set_end) begin
            acc_shunt <= '0;
            acc_bus   <= '0;
        end else if (conv_end && state == MCR_CONV_SHUNT) begin
            acc_shunt <= next_acc_shunt;
        end else if (conv_end && state == MCR_CONV_BUS) begin
            acc_bus <= next_acc_bus;
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Arithmetic shift keeps the sign of reverse current; LSB stays 1.25 mA
    always_ff @(posedge mclk) begin
        if (reset || soft_reset) begin
            current_result     <= MCR_RESULT_RESET;
            bus_voltage_result <= MCR_RESULT_RESET;
        end else if (set_end && !cfg_write) begin
            // A write in the same cycle aborts the set, so nothing is posted
            if (do_shunt) begin
                current_result <= 16'(shunt_total >>>
                                      avg_shift(cfg.sample_average_count));
            end
            if (do_bus) begin
                // 15-bit input keeps bit 15 clear; 1.25 mV per count
                bus_voltage_result <= {1'b0, 15'(next_acc_bus >>
                                      avg_shift(cfg.sample_average_count))};
            end
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            conv_busy  <= 1'b0;
            conv_ready <= 1'b0;
        end else begin
            conv_busy  <= (state != MCR_IDLE) && powered && !cfg_write;
            conv_ready <= set_end && !cfg_write;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Reads have no side effect on settings or the sequencer
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_req.rd) begin
            if (reg_req.addr == MCR_ADDR_CONFIG) begin
                reg_rdata <= cfg;
            end else if (reg_req.addr == MCR_ADDR_CURRENT) begin
                reg_rdata <= current_result;
            end else if (reg_req.addr == MCR_ADDR_BUS) begin
                reg_rdata <= bus_voltage_result;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

endmodule

// ---- verification/mcr_sense_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Sense front end: physical value to code
// ----------------------------------------
module mcr_sense_model (
    input  wire logic signed [31:0] current_ua,
    input  wire logic signed [31:0] bus_uv,
    output logic [15:0]             shunt_sample,
    output logic [14:0]             bus_voltage_reading
);
    // 1.25 mA per count, signed so reverse flow is negative
    assign shunt_sample = 16'(current_ua / 1250);
    // 1.25 mV per count, clipped at the top code
    assign bus_voltage_reading = (bus_uv >= 40960000) ? 15'h7fff : 15'(bus_uv / 1250);
endmodule

// ---- verification/mcr_monitor_assertions.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module mcr_monitor_assertions
    import mcr_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire mcr_req_t    reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] shunt_sample,
    input wire logic [14:0] bus_voltage_reading,
    input wire logic [15:0] current_result,
    input wire logic [15:0] bus_voltage_result,
    input wire logic        conv_busy,
    input wire logic        conv_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Decoded requests; a read with a write beside it is left out
    wire logic cfg_wr = reg_req.wr && reg_req.addr == MCR_ADDR_CONFIG;
    wire logic sr     = cfg_wr && reg_req.wdata[MCR_SOFT_RST_BIT];
    wire logic pd     = cfg_wr && !reg_req.wdata[15] && reg_req.wdata[1:0] == 2'h0;
    wire logic rd_ok  = reg_req.rd && !reg_req.wr;
    wire logic rd0    = rd_ok && reg_req.addr == MCR_ADDR_CONFIG;

    a_bus_msb_zero: assert property (!bus_voltage_result[15])
        else $error("bus result msb set");
    a_cur_at_ready: assert property (
        ($changed(current_result) && !$past(sr) && !$past(reset)) |-> conv_ready)
        else $error("current result moved outside a set end");
    a_bus_at_ready: assert property (
        ($changed(bus_voltage_result) && !$past(sr) && !$past(reset)) |-> conv_ready)
        else $error("bus result moved outside a set end");
    a_cfg_fixed_bits: assert property (rd0 |=> reg_rdata[15:12] == 4'h6)
        else $error("config top bits wrong");
    a_cfg_read_stable: assert property (rd0 ##1 rd0 |=> $stable(reg_rdata))
        else $error("config read disturbed");
    a_cur_readback: assert property (rd_ok && reg_req.addr == MCR_ADDR_CURRENT |=> reg_rdata == $past(current_result))
        else $error("current read mismatch");
    a_bus_readback: assert property (rd_ok && reg_req.addr == MCR_ADDR_BUS |=> reg_rdata == $past(bus_voltage_result))
        else $error("bus read mismatch");
    a_soft_rst_clear: assert property (sr |=> current_result == 16'h0 && bus_voltage_result == 16'h0)
        else $error("soft reset left results");
    a_pwrdown_quiet: assert property (pd |-> ##2 !conv_busy [*8])
        else $error("converting in power-down");
    a_write_restart: assert property (
        (cfg_wr && !reg_req.wdata[15] && reg_req.wdata[1:0] != 2'h0)
        ##1 (!reg_req.wr) [*2] |-> ##1 conv_busy)
        else $error("no new conversion after config write");

    c_ready: cover property (conv_ready);
    c_soft: cover property (sr);
    c_cfg_reads: cover property (rd0 ##1 rd0);
endmodule

bind mcr_monitor mcr_monitor_assertions u_chk (
    .mclk(mclk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .shunt_sample(shunt_sample), .bus_voltage_reading(bus_voltage_reading),
    .current_result(current_result), .bus_voltage_result(bus_voltage_result),
    .conv_busy(conv_busy), .conv_ready(conv_ready));

// ---- verification/tb.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Testbench
// ----------------------------------------
module tb
    import mcr_pkg::*;
;
    // Short conversions keep the 1024-sample runs affordable
    localparam int unsigned CYC [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
    localparam int          NS [8]  = '{1, 4, 16, 64, 128, 256, 512, 1024};

    logic               mclk   = 1'b0;
    logic               reset  = 1'b1;
    mcr_req_t           req    = '0;
    logic [15:0]        rdata;
    logic [15:0]        shunt;
    logic [14:0]        busv;
    logic [15:0]        cur_res;
    logic [15:0]        bus_res;
    logic               conv_ready;
    logic               busy;
    logic signed [31:0] cur_ua = -20000;
    logic signed [31:0] bus_uv = 40960000;
    int                 err_count = 0;
    int                 comparisons = 0;
    int                 n;

    mcr_monitor #(.CONV_CYC(CYC)) u_dut (
        .mclk(mclk), .reset(reset), .reg_req(req), .reg_rdata(rdata),
        .shunt_sample(shunt), .bus_voltage_reading(busv), .current_result(cur_res),
        .bus_voltage_result(bus_res), .conv_busy(busy), .conv_ready(conv_ready));
    mcr_sense_model u_sense (.current_ua(cur_ua), .bus_uv(bus_uv),
        .shunt_sample(shunt), .bus_voltage_reading(busv));

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Bus tasks start just after a falling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge mclk);
        req.wr = 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge mclk);
        req.rd = 1'b0;
        @(negedge mclk);
        chk(nm, rdata, e);
    endtask

    // Bounded wait for the next set-complete pulse
    task automatic gap(input int lim, output int k);
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (conv_ready !== 1'b1 && k < lim);
    endtask

    // Second pulse after a config write gives the set period
    task automatic meas(input logic [15:0] cfg, input int p);
        int k;
        wr(MCR_ADDR_CONFIG, cfg);
        gap(p + 20, k);
        gap(p + 20, k);
        chk("interval", 16'(k), 16'(p));
    endtask

    task automatic conclude();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 33k cycles
    initial begin
        #(80000 * 4);
        err_count++;
        conclude();
    end

    initial begin
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        rc(MCR_ADDR_CONFIG, 16'h6127, "config_rst");
        rc(MCR_ADDR_BUS, 16'h0000, "bus_rst");
        gap(40, n);
        chk("first_set", 16'(conv_ready), 16'h1);
        rc(MCR_ADDR_CURRENT, 16'hfff0, "current");
        rc(MCR_ADDR_BUS, 16'h7fff, "bus");
        $display("test reset and scaling done");
        for (int i = 0; i < 8; i++) begin
            meas({10'h0, i[2:0], 3'h5}, CYC[i]);
            meas({7'h0, i[2:0], 6'h6}, CYC[i]);
        end
        $display("test conversion times done");
        for (int a = 0; a < 8; a++) begin
            meas({4'h0, a[2:0], 9'h007}, NS[a] * 8);
            rc(MCR_ADDR_CURRENT, 16'hfff0, "avg_current");
            rc(MCR_ADDR_BUS, 16'h7fff, "avg_bus");
            chk("avg_busy", 16'(busy), 16'h1);
        end
        $display("test averaging done");
        for (int m = 1; m < 4; m++) begin
            wr(MCR_ADDR_CONFIG, {13'h0, m[2:0]});
            gap(40, n);
            chk("trig_set", 16'(n < 40), 16'h1);
            gap(100, n);
            chk("trig_quiet", 16'(n), 16'h64);
            chk("trig_idle", 16'(busy), 16'h0);
        end
        for (int m = 0; m < 8; m += 4) begin
            wr(MCR_ADDR_CONFIG, {13'h0, m[2:0]});
            gap(100, n);
            chk("pd_quiet", 16'(n), 16'h64);
            chk("pd_busy", 16'(busy), 16'h0);
        end
        $display("test modes done");
        wr(MCR_ADDR_CONFIG, 16'hffff);
        // Back-to-back config reads
        req.rd = 1'b1;
        req.addr = MCR_ADDR_CONFIG;
        repeat (2) @(negedge mclk);
        req.rd = 1'b0;
        rc(MCR_ADDR_CONFIG, 16'h6127, "config_soft");
        rc(MCR_ADDR_CURRENT, 16'h0000, "current_soft");
        $display("test soft reset done");
        conclude();
    end
endmodule
